// [verilog/cch_defs.vh]
// Constants for the common command handler
`ifndef CCH_DEFS_VH
`define CCH_DEFS_VH
`define CCH_A_CMD      4'h0
`define CCH_A_ARG      4'h1
`define CCH_A_RESP     4'h2
`define CCH_A_STAT     4'h3
`define CCH_A_ESE      4'h4
`define CCH_A_ESR      4'h5
`define CCH_A_SRE      4'h6
`define CCH_A_STB      4'h7
`define CCH_A_CHAN     4'h8
`define CCH_A_SCAN     4'h9
`define CCH_A_IRQST    4'ha
`define CCH_A_IRQMSK   4'hb
`define CCH_A_OPER     4'hc
`define CCH_OP_CLS     4'h1
`define CCH_OP_ESE     4'h2
`define CCH_OP_ESEQ    4'h3
`define CCH_OP_ESRQ    4'h4
`define CCH_OP_IDNQ    4'h5
`define CCH_OP_OPC     4'h6
`define CCH_OP_OPCQ    4'h7
`define CCH_OP_RCL     4'h8
`define CCH_OP_RST     4'h9
`define CCH_OP_SAV     4'ha
`define CCH_OP_SRE     4'hb
`define CCH_OP_SREQ    4'hc
`define CCH_OP_STBQ    4'hd
`define CCH_OP_TRG     4'he
`define CCH_OP_TSTQ    4'hf
`define CCH_OP_WAI     4'h0
`define CCH_ESR_OPC    0
`define CCH_STB_ESB    5
`define CCH_STB_RQS    6
`define CCH_STB_OPER   7
`define CCH_TRIG_BUS   3'h0
`define CCH_TRIG_EXT   3'h1
`define CCH_TRIG_HOLD  3'h2
`define CCH_TRIG_IMM   3'h3
`define CCH_TRIG_TTLT  3'h4
`define CCH_TST_PASS   16'h0000
`define CCH_TST_FW     16'hcc01
`define CCH_TST_BUS    16'hcc02
`define CCH_TST_IRQ    16'hcc10
`define CCH_TST_BUSY   16'hcc11
`define CCH_OPC_ONE    32'h0000_0001
`define CCH_BUSY_MS    10
`define CCH_CLK_KHZ    25000
`define CCH_SLOTS      10
`define CCH_IRQ_DONE   0
`define CCH_IRQ_RESP   1
`define CCH_IRQ_TRG    2
`define CCH_BAD_ADDR   32'hdead_0bad
`endif

// [verilog/cch_top.v]
// Common command handler with AXI4-Lite register access
`timescale 1ns/1ps
`include "cch_defs.vh"
module cch_top #(
    parameter        IDN_WORD   = 32'h1234_5678, // Arbitrary identity value
    parameter [31:0] BUSY_TICKS = (`CCH_BUSY_MS * `CCH_CLK_KHZ)
) (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [31:0] s_axil_awaddr,
    input  wire        s_axil_awvalid,
    output wire        s_axil_awready,
    input  wire [31:0] s_axil_wdata,
    input  wire [3:0]  s_axil_wstrb,
    input  wire        s_axil_wvalid,
    output wire        s_axil_wready,
    output reg  [1:0]  s_axil_bresp,
    output reg         s_axil_bvalid,
    input  wire        s_axil_bready,
    input  wire [31:0] s_axil_araddr,
    input  wire        s_axil_arvalid,
    output wire        s_axil_arready,
    output reg  [31:0] s_axil_rdata,
    output reg  [1:0]  s_axil_rresp,
    output reg         s_axil_rvalid,
    input  wire        s_axil_rready,
    input  wire        ops_pending,
    input  wire        st_fw_err,
    input  wire        st_bus_err,
    input  wire        st_irq_seen,
    input  wire        st_busy,
    input  wire [7:0]  oper_event_in,
    output reg  [15:0] chan_close_r,
    output reg         scan_step_r,
    output wire        srq,
    output wire        irq
);
    localparam ST_IDLE = 4'b0001;
    localparam ST_WAIT = 4'b0010;
    localparam ST_TEST = 4'b0100;
    localparam ST_DONE = 4'b1000;

    reg  [3:0]  state_r;
    reg  [3:0]  op_r;
    reg  [31:0] arg_r;
    reg  [31:0] resp_r;
    reg         resp_vld_r;
    reg  [7:0]  ese_r;
    reg  [7:0]  esr_r;
    reg  [7:0]  sre_r;
    reg  [7:0]  oper_r;
    reg         opc_req_r;
    reg         scan_en_r;
    reg  [2:0]  trig_src_r;
    reg  [2:0]  irq_st_r;
    reg  [2:0]  irq_msk_r;
    reg  [31:0] tcnt_r;
    reg         busy_ok_r;
    reg  [15:0] slot_mem [0:`CCH_SLOTS-1];
    reg  [3:0]  aw_a_r;
    reg         aw_have_r;
    reg  [31:0] w_d_r;
    reg         w_have_r;
    reg         ar_busy_r;
    integer     i;

    wire [7:0] stb_w;
    wire       do_wr;
    wire       cmd_go;
    wire       done_ev;
    wire       resp_ev;
    wire       trg_ev;
    wire       rd_esr;
    wire       rd_resp;
    wire       esb_w;
    wire       rqs_w;
    wire [3:0] ar_idx;

    function ok_slot;
        input [31:0] a;
        begin
            ok_slot = (a < `CCH_SLOTS);
        end
    endfunction

    function [3:0] word_idx;
        input [31:0] a;
        begin
            word_idx = a[5:2];
        end
    endfunction

    function is_query;
        input [3:0] op;
        begin
            is_query = (op == `CCH_OP_ESEQ) || (op == `CCH_OP_ESRQ) || (op == `CCH_OP_IDNQ) ||
                       (op == `CCH_OP_OPCQ) || (op == `CCH_OP_SREQ) || (op == `CCH_OP_STBQ) ||
                       (op == `CCH_OP_TSTQ);
        end
    endfunction

    // Status byte with summary bits
    assign esb_w  = |(esr_r & ese_r);
    assign rqs_w  = |({1'b0, esb_w, 5'h00} & sre_r[6:0]);
    assign stb_w  = {(|oper_r), rqs_w, esb_w, 5'h00};
    assign ar_idx = word_idx(s_axil_araddr);

    assign srq = stb_w[`CCH_STB_RQS];
    assign irq = |(irq_st_r & irq_msk_r);

    assign s_axil_awready = !aw_have_r && !s_axil_bvalid;
    assign s_axil_wready  = !w_have_r && !s_axil_bvalid;
    assign s_axil_arready = !ar_busy_r;
    assign do_wr   = aw_have_r && w_have_r && !s_axil_bvalid;
    // Commands accepted only while idle
    assign cmd_go  = do_wr && (aw_a_r == `CCH_A_CMD) && (state_r == ST_IDLE);
    assign rd_esr  = s_axil_arvalid && s_axil_arready && (ar_idx == `CCH_A_ESR);
    assign rd_resp = s_axil_arvalid && s_axil_arready && (ar_idx == `CCH_A_RESP);
    assign done_ev = (state_r == ST_DONE);
    assign resp_ev = done_ev && is_query(op_r);
    assign trg_ev  = done_ev && (op_r == `CCH_OP_TRG) && scan_en_r && (trig_src_r == `CCH_TRIG_BUS);

    // Write channels
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r     <= 1'b0;
            w_have_r      <= 1'b0;
            aw_a_r        <= 4'h0;
            w_d_r         <= 32'h0000_0000;
            s_axil_bvalid <= 1'b0;
            s_axil_bresp  <= 2'h0;
        end else begin
            if (s_axil_awvalid && s_axil_awready) begin
                aw_have_r <= 1'b1;
                aw_a_r    <= word_idx(s_axil_awaddr);
            end
            if (s_axil_wvalid && s_axil_wready) begin
                w_have_r <= 1'b1;
                w_d_r    <= s_axil_wdata;
            end
            if (do_wr) begin
                aw_have_r     <= 1'b0;
                w_have_r      <= 1'b0;
                s_axil_bvalid <= 1'b1;
                s_axil_bresp  <= (aw_a_r > `CCH_A_OPER) ? 2'h2 : 2'h0;
            end else if (s_axil_bvalid && s_axil_bready) begin
                s_axil_bvalid <= 1'b0;
            end
        end
    end

    // Read channel
    always @(posedge aclk) begin
        if (!aresetn) begin
            ar_busy_r     <= 1'b0;
            s_axil_rvalid <= 1'b0;
            s_axil_rdata  <= 32'h0000_0000;
            s_axil_rresp  <= 2'h0;
        end else if (s_axil_arvalid && s_axil_arready) begin
            ar_busy_r     <= 1'b1;
            s_axil_rvalid <= 1'b1;
            s_axil_rresp  <= 2'h0;
            if (s_axil_araddr[5:2] == `CCH_A_CMD)
                s_axil_rdata <= {28'h0, op_r};
            else if (s_axil_araddr[5:2] == `CCH_A_ARG)
                s_axil_rdata <= arg_r;
            else if (s_axil_araddr[5:2] == `CCH_A_RESP)
                s_axil_rdata <= resp_r;
            else if (s_axil_araddr[5:2] == `CCH_A_STAT)
                s_axil_rdata <= {27'h0, resp_vld_r, opc_req_r, (state_r != ST_IDLE), 2'h0};
            else if (s_axil_araddr[5:2] == `CCH_A_ESE)
                s_axil_rdata <= {24'h0, ese_r};
            else if (s_axil_araddr[5:2] == `CCH_A_ESR)
                s_axil_rdata <= {24'h0, esr_r};
            else if (s_axil_araddr[5:2] == `CCH_A_SRE)
                s_axil_rdata <= {24'h0, sre_r};
            else if (s_axil_araddr[5:2] == `CCH_A_STB)
                s_axil_rdata <= {24'h0, stb_w};
            else if (s_axil_araddr[5:2] == `CCH_A_CHAN)
                s_axil_rdata <= {16'h0, chan_close_r};
            else if (s_axil_araddr[5:2] == `CCH_A_SCAN)
                s_axil_rdata <= {28'h0, trig_src_r, scan_en_r};
            else if (s_axil_araddr[5:2] == `CCH_A_IRQST)
                s_axil_rdata <= {29'h0, irq_st_r};
            else if (s_axil_araddr[5:2] == `CCH_A_IRQMSK)
                s_axil_rdata <= {29'h0, irq_msk_r};
            else if (s_axil_araddr[5:2] == `CCH_A_OPER)
                s_axil_rdata <= {24'h0, oper_r};
            else begin
                s_axil_rdata <= `CCH_BAD_ADDR;
                s_axil_rresp <= 2'h2;
            end
        end else if (s_axil_rvalid && s_axil_rready) begin
            s_axil_rvalid <= 1'b0;
            ar_busy_r     <= 1'b0;
        end
    end

    // Command engine
    always @(posedge aclk) begin
        if (!aresetn) begin
            state_r      <= ST_IDLE;
            op_r         <= 4'h0;
            arg_r        <= 32'h0000_0000;
            resp_r       <= 32'h0000_0000;
            resp_vld_r   <= 1'b0;
            ese_r        <= 8'h00;
            esr_r        <= 8'h00;
            sre_r        <= 8'h00;
            oper_r       <= 8'h00;
            opc_req_r    <= 1'b0;
            scan_en_r    <= 1'b0;
            trig_src_r   <= `CCH_TRIG_IMM;
            chan_close_r <= 16'h0000;
            scan_step_r  <= 1'b0;
            irq_st_r     <= 3'h0;
            irq_msk_r    <= 3'h0;
            tcnt_r       <= 32'h0000_0000;
            busy_ok_r    <= 1'b0;
            for (i = 0; i < `CCH_SLOTS; i = i + 1) begin
                slot_mem[i] <= 16'h0000;
            end
        end else begin
            scan_step_r <= trg_ev;
            oper_r      <= oper_r | oper_event_in;
            if (rd_resp) begin
                resp_vld_r <= 1'b0;
            end
            if (rd_esr) begin
                esr_r <= 8'h00;
            end
            if (do_wr && aw_a_r == `CCH_A_ARG) begin
                arg_r <= w_d_r;
            end
            if (do_wr && aw_a_r == `CCH_A_CHAN) begin
                chan_close_r <= w_d_r[15:0];
            end
            if (do_wr && aw_a_r == `CCH_A_SCAN) begin
                scan_en_r  <= w_d_r[0];
                trig_src_r <= w_d_r[3:1];
            end
            if (do_wr && aw_a_r == `CCH_A_IRQMSK) begin
                irq_msk_r <= w_d_r[2:0];
            end
            // Set wins over write-one-clear
            irq_st_r <= ((do_wr && aw_a_r == `CCH_A_IRQST) ? (irq_st_r & ~w_d_r[2:0]) : irq_st_r)
                        | {trg_ev, resp_ev, done_ev};
            case (state_r)
                ST_IDLE: begin
                    if (cmd_go) begin
                        op_r <= w_d_r[3:0];
                        if (w_d_r[3:0] == `CCH_OP_TSTQ) begin
                            tcnt_r    <= 32'h0000_0000;
                            busy_ok_r <= 1'b1;
                            state_r   <= ST_TEST;
                        end else if (w_d_r[3:0] == `CCH_OP_OPC || w_d_r[3:0] == `CCH_OP_OPCQ ||
                                     w_d_r[3:0] == `CCH_OP_WAI) begin
                            state_r <= ST_WAIT;
                        end else begin
                            state_r <= ST_DONE;
                        end
                    end
                end
                ST_WAIT: begin
                    if (!ops_pending) begin
                        state_r <= ST_DONE;
                    end
                end
                ST_TEST: begin
                    tcnt_r <= tcnt_r + 32'h0000_0001;
                    if (!st_busy) begin
                        busy_ok_r <= 1'b0;
                    end
                    if (tcnt_r >= BUSY_TICKS - 32'h0000_0001) begin
                        state_r <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    state_r <= ST_IDLE;
                    case (op_r)
                        `CCH_OP_CLS: begin
                            esr_r     <= 8'h00;
                            oper_r    <= 8'h00;
                            opc_req_r <= 1'b0;
                            irq_st_r  <= 3'h0;
                        end
                        `CCH_OP_ESE: begin
                            ese_r <= arg_r[7:0];
                        end
                        `CCH_OP_ESEQ: begin
                            resp_r <= {24'h0, ese_r};
                        end
                        `CCH_OP_ESRQ: begin
                            resp_r <= {24'h0, esr_r};
                            esr_r  <= 8'h00;
                        end
                        `CCH_OP_IDNQ: begin
                            resp_r <= IDN_WORD;
                        end
                        `CCH_OP_OPC: begin
                            opc_req_r            <= 1'b1;
                            esr_r[`CCH_ESR_OPC]  <= 1'b1;
                        end
                        `CCH_OP_OPCQ: begin
                            resp_r <= `CCH_OPC_ONE;
                        end
                        `CCH_OP_RCL: begin
                            if (ok_slot(arg_r)) begin
                                chan_close_r <= slot_mem[arg_r[3:0]];
                            end
                        end
                        `CCH_OP_SAV: begin
                            if (ok_slot(arg_r)) begin
                                slot_mem[arg_r[3:0]] <= chan_close_r;
                            end
                        end
                        `CCH_OP_RST: begin
                            chan_close_r <= 16'h0000;
                            scan_en_r    <= 1'b0;
                            trig_src_r   <= `CCH_TRIG_IMM;
                        end
                        `CCH_OP_SRE: begin
                            sre_r <= {1'b0, arg_r[6:0]};
                        end
                        `CCH_OP_SREQ: begin
                            resp_r <= {24'h0, sre_r};
                        end
                        `CCH_OP_STBQ: begin
                            resp_r <= {24'h0, stb_w};
                        end
                        `CCH_OP_TSTQ: begin
                            if (st_fw_err) begin
                                resp_r <= {16'h0, `CCH_TST_FW};
                            end else if (st_bus_err) begin
                                resp_r <= {16'h0, `CCH_TST_BUS};
                            end else if (!st_irq_seen) begin
                                resp_r <= {16'h0, `CCH_TST_IRQ};
                            end else if (!busy_ok_r) begin
                                resp_r <= {16'h0, `CCH_TST_BUSY};
                            end else begin
                                resp_r <= {16'h0, `CCH_TST_PASS};
                            end
                        end
                        default: ;
                    endcase
                    if (resp_ev) begin
                        resp_vld_r <= 1'b1;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end
endmodule

// [sim/cch_asserts.sv]
// Port checks for the common command handler
`timescale 1ns/1ps
`include "cch_defs.vh"
module cch_asserts (
    input wire        aclk,
    input wire        aresetn,
    input wire [31:0] s_axil_awaddr,
    input wire        s_axil_awvalid,
    input wire        s_axil_awready,
    input wire        s_axil_wvalid,
    input wire        s_axil_wready,
    input wire [1:0]  s_axil_bresp,
    input wire        s_axil_bvalid,
    input wire        s_axil_bready,
    input wire [31:0] s_axil_araddr,
    input wire        s_axil_arvalid,
    input wire        s_axil_arready,
    input wire [31:0] s_axil_rdata,
    input wire [1:0]  s_axil_rresp,
    input wire        s_axil_rvalid,
    input wire        s_axil_rready,
    input wire [15:0] chan_close_r,
    input wire        scan_step_r,
    input wire        srq,
    input wire        irq
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    property p_rst; disable iff (1'b0) !aresetn |=> chan_close_r == 16'h0 && !srq && !irq && !scan_step_r; endproperty
    a_rst: assert property (p_rst) else $error("Outputs not cleared by reset");
    property p_bad; s_axil_arvalid && s_axil_arready && s_axil_araddr > 32'h30 && s_axil_araddr < 32'h40
        |-> ##[1:2] (s_axil_rvalid && s_axil_rresp == 2'b10 && s_axil_rdata == `CCH_BAD_ADDR); endproperty
    a_bad: assert property (p_bad) else $error("Unmapped read not refused");
    property p_rok; s_axil_arvalid && s_axil_arready && s_axil_araddr <= 32'h30
        |-> ##[1:2] (s_axil_rvalid && s_axil_rresp == 2'b00); endproperty
    a_rok: assert property (p_rok) else $error("Mapped read not answered");
    property p_wr; s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready && s_axil_awaddr <= 32'h30
        |-> ##[1:2] (s_axil_bvalid && s_axil_bresp == 2'b00); endproperty
    a_wr: assert property (p_wr) else $error("Write not answered");
    property p_bdrop; s_axil_bvalid && s_axil_bready |=> !s_axil_bvalid; endproperty
    a_bdrop: assert property (p_bdrop) else $error("Write answer repeated");
    property p_rdrop; s_axil_rvalid && s_axil_rready |=> !s_axil_rvalid; endproperty
    a_rdrop: assert property (p_rdrop) else $error("Read answer repeated");
    property p_step; scan_step_r |=> !scan_step_r; endproperty
    a_step: assert property (p_step) else $error("Scan step longer than one cycle");
    property p_chan; $changed(chan_close_r) |-> s_axil_bvalid || $past(s_axil_bvalid) || $past(s_axil_bvalid, 2); endproperty
    a_chan: assert property (p_chan) else $error("Channels changed without a write");
endmodule
bind cch_top cch_asserts cch_asserts_inst (.aclk(aclk), .aresetn(aresetn), .s_axil_awaddr(s_axil_awaddr),
    .s_axil_awvalid(s_axil_awvalid), .s_axil_awready(s_axil_awready), .s_axil_wvalid(s_axil_wvalid),
    .s_axil_wready(s_axil_wready), .s_axil_bresp(s_axil_bresp), .s_axil_bvalid(s_axil_bvalid),
    .s_axil_bready(s_axil_bready), .s_axil_araddr(s_axil_araddr), .s_axil_arvalid(s_axil_arvalid),
    .s_axil_arready(s_axil_arready), .s_axil_rdata(s_axil_rdata), .s_axil_rresp(s_axil_rresp),
    .s_axil_rvalid(s_axil_rvalid), .s_axil_rready(s_axil_rready), .chan_close_r(chan_close_r),
    .scan_step_r(scan_step_r), .srq(srq), .irq(irq));

// [sim/cch_host.sv]
// AXI4-Lite host model issuing common commands
`timescale 1ns/1ps
module cch_host (
    input  wire        aclk,
    output reg  [31:0] awaddr,
    output reg         awvalid,
    input  wire        awready,
    output reg  [31:0] wdata,
    output reg         wvalid,
    input  wire        wready,
    input  wire        bvalid,
    output reg         bready,
    output reg  [31:0] araddr,
    output reg         arvalid,
    input  wire        arready,
    input  wire [31:0] rdata,
    input  wire [1:0]  rresp,
    input  wire        rvalid,
    output reg         rready
);
    reg done;
    initial begin
        {awaddr, awvalid, wdata, wvalid, araddr, arvalid} = 0;
        bready = 1'b1;
        rready = 1'b1;
    end
    // One transfer at a time, request held until taken
    task wr(input [31:0] a, input [31:0] d);
        begin
            awaddr  <= a;
            wdata   <= d;
            awvalid <= 1'b1;
            wvalid  <= 1'b1;
            done = 1'b0;
            while (!done) begin
                @(posedge aclk);
                if (awvalid && awready) awvalid <= 1'b0;
                if (wvalid && wready) wvalid <= 1'b0;
                if (bvalid) done = 1'b1;
            end
        end
    endtask
    task rd(input [31:0] a, output [31:0] d, output [1:0] r);
        begin
            araddr  <= a;
            arvalid <= 1'b1;
            done = 1'b0;
            while (!done) begin
                @(posedge aclk);
                if (arvalid && arready) arvalid <= 1'b0;
                if (rvalid) begin
                    d = rdata;
                    r = rresp;
                    done = 1'b1;
                end
            end
        end
    endtask
endmodule

// [sim/tb_top.sv]
// Self-checking bench for the common command handler
`timescale 1ns/1ps
`include "cch_defs.vh"
module tb_top;
    localparam [31:0] IDN = 32'h5a5a_0001; // Arbitrary identity word
    localparam [19:0] TST = 20'h21783;
    localparam [11:0] OPS = 12'h706;
    reg         aclk = 1'b0;
    reg         aresetn = 1'b0;
    reg         pend = 1'b0;
    reg  [3:0]  st = 4'h3;
    reg  [7:0]  oev = 8'h00;
    reg  [31:0] seed, v, d;
    reg  [1:0]  r;
    reg  [3:0]  val;
    integer     n_fail = 0, total_checks = 0, i, steps = 0, cyc = 0;
    wire [31:0] awaddr, wdata, araddr, rdata;
    wire [1:0]  bresp, rresp;
    wire [15:0] chan;
    wire        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, step, srq, irq;
    always #20 aclk = ~aclk;
    cch_host host_inst (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
    cch_top #(.IDN_WORD(IDN), .BUSY_TICKS(32'd20)) cch_top_inst (.aclk(aclk), .aresetn(aresetn),
        .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid), .s_axil_awready(awready), .s_axil_wdata(wdata),
        .s_axil_wstrb(4'hf), .s_axil_wvalid(wvalid), .s_axil_wready(wready), .s_axil_bresp(bresp),
        .s_axil_bvalid(bvalid), .s_axil_bready(bready), .s_axil_araddr(araddr), .s_axil_arvalid(arvalid),
        .s_axil_arready(arready), .s_axil_rdata(rdata), .s_axil_rresp(rresp), .s_axil_rvalid(rvalid),
        .s_axil_rready(rready), .ops_pending(pend), .st_fw_err(st[3]), .st_bus_err(st[2]),
        .st_irq_seen(st[1]), .st_busy(st[0]), .oper_event_in(oev), .chan_close_r(chan),
        .scan_step_r(step), .srq(srq), .irq(irq));
    always @(posedge aclk) if (step === 1'b1) steps <= steps + 1;
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            n_fail = n_fail + 1;
            summarize;
        end
    end
    function [31:0] xs(input [31:0] s);
        reg [31:0] x;
        begin
            x = s ^ (s << 13);
            x = x ^ (x >> 17);
            xs = x ^ (x << 5);
        end
    endfunction
    function [31:0] ad(input [3:0] a);
        ad = {26'h0, a, 2'b00};
    endfunction
    function [15:0] tst_exp(input [3:0] s);
        tst_exp = s[3] ? `CCH_TST_FW : s[2] ? `CCH_TST_BUS :
                  !s[1] ? `CCH_TST_IRQ : !s[0] ? `CCH_TST_BUSY : `CCH_TST_PASS;
    endfunction
    task chk(input [31:0] got, input [31:0] exp);
        begin
            total_checks = total_checks + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("BAD %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task rg(input [3:0] a);
        host_inst.rd(ad(a), d, r);
    endtask
    task cmd(input [3:0] op, input [31:0] arg);
        begin
            host_inst.wr(ad(`CCH_A_ARG), arg);
            host_inst.wr(ad(`CCH_A_CMD), {28'h0, op});
        end
    endtask
    task idle;
        integer k;
        for (k = 0; k < 200; k = k + 1) begin
            rg(`CCH_A_STAT);
            if (d[2] === 1'b0) k = 200;
        end
    endtask
    task run(input [3:0] op, input [31:0] arg);
        begin
            cmd(op, arg);
            idle;
        end
    endtask
    task ask(input [3:0] op);
        begin
            run(op, 32'h0);
            rg(`CCH_A_RESP);
        end
    endtask
    task summarize;
        begin
            if (n_fail == 0 && total_checks > 0) begin
                $display("All tests passed");
            end else begin
                $display("Some tests failed");
            end
            $finish;
        end
    endtask
    initial begin
        seed = 32'hc1b3068c;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rg(`CCH_A_SCAN);
        chk(d, {28'h0, `CCH_TRIG_IMM, 1'b0});
        seed = xs(seed);
        v = {16'h0, seed[15:0]};
        host_inst.wr(ad(`CCH_A_CHAN), v);
        run(`CCH_OP_SAV, 32'h9);
        host_inst.wr(ad(`CCH_A_CHAN), v ^ 32'hffff);
        run(`CCH_OP_RCL, 32'h9);
        rg(`CCH_A_CHAN);
        chk(d, v);
        chk({16'h0, chan}, v);
        host_inst.wr(ad(`CCH_A_SCAN), 32'h1);
        run(`CCH_OP_RST, 32'h0);
        chk({16'h0, chan}, 32'h0);
        rg(`CCH_A_SCAN);
        chk(d, 32'h6);
        for (i = 0; i < 6; i = i + 1) begin
            val = (i < 5) ? {i[2:0], 1'b1} : 4'h0;
            host_inst.wr(ad(`CCH_A_SCAN), {28'h0, val});
            rg(`CCH_A_SCAN);
            chk(d, {28'h0, val});
            v = steps;
            run(`CCH_OP_TRG, 32'h0);
            chk(steps - v, {31'h0, val == 4'h1});
        end
        seed = xs(seed);
        run(`CCH_OP_ESE, {24'h0, seed[7:0]});
        ask(`CCH_OP_ESEQ);
        chk(d, {24'h0, seed[7:0]});
        ask(`CCH_OP_ESEQ);
        chk(d, {24'h0, seed[7:0]});
        for (i = 0; i < 3; i = i + 1) begin
            pend <= 1'b1;
            cmd(OPS[4 * i +: 4], 32'h0);
            repeat (8) @(posedge aclk);
            rg(`CCH_A_STAT);
            chk({30'h0, d[4], d[2]}, 32'h1);
            pend <= 1'b0;
            idle;
        end
        rg(`CCH_A_RESP);
        chk(d, `CCH_OPC_ONE);
        rg(`CCH_A_STAT);
        chk({31'h0, d[3]}, 32'h1);
        ask(`CCH_OP_ESRQ);
        chk(d, 32'h1);
        ask(`CCH_OP_ESRQ);
        chk(d, 32'h0);
        host_inst.wr(ad(`CCH_A_IRQMSK), 32'h2);
        host_inst.wr(ad(`CCH_A_IRQST), 32'h7);
        chk({31'h0, irq}, 32'h0);
        run(`CCH_OP_IDNQ, 32'h0);
        chk({31'h0, irq}, 32'h1);
        host_inst.wr(ad(`CCH_A_IRQMSK), 32'h0);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq}, 32'h0);
        host_inst.wr(ad(`CCH_A_IRQST), 32'h7);
        rg(`CCH_A_IRQST);
        chk(d, 32'h0);
        rg(`CCH_A_RESP);
        chk(d, IDN);
        run(`CCH_OP_SRE, 32'h20);
        run(`CCH_OP_ESE, 32'h1);
        run(`CCH_OP_OPC, 32'h0);
        chk({31'h0, srq}, 32'h1);
        ask(`CCH_OP_STBQ);
        chk(d, 32'h60);
        ask(`CCH_OP_SREQ);
        chk(d, 32'h20);
        seed = xs(seed);
        oev <= seed[7:0] | 8'h01;
        @(posedge aclk);
        oev <= 8'h00;
        rg(`CCH_A_OPER);
        chk(d, {24'h0, seed[7:0] | 8'h01});
        run(`CCH_OP_CLS, 32'h0);
        rg(`CCH_A_OPER);
        chk(d, 32'h0);
        rg(`CCH_A_ESR);
        chk(d, 32'h0);
        chk({31'h0, srq}, 32'h0);
        rg(`CCH_A_STAT);
        chk({31'h0, d[3]}, 32'h0);
        for (i = 0; i < 8; i = i + 1) begin
            seed = xs(seed);
            val = (i < 5) ? TST[4 * i +: 4] : seed[3:0];
            st <= val;
            ask(`CCH_OP_TSTQ);
            chk({16'h0, d[15:0]}, {16'h0, tst_exp(val)});
        end
        host_inst.rd(32'h34, d, r);
        chk(d, `CCH_BAD_ADDR);
        chk({30'h0, r}, 32'h2);
        summarize;
    end
endmodule
